// ===== logic/iam_pkg.sv
package iam_pkg;

   // source counts: external lines, on-chip sources, level groups
   localparam int unsigned NUM_EXT       = 8;
   localparam int unsigned NUM_INT       = 34;
   localparam int unsigned NUM_SRC       = NUM_EXT + NUM_INT;
   localparam int unsigned NUM_GRP       = 16;

   // vector numbers
   localparam logic [7:0]  VEC_NONMASK   = 8'h07;
   localparam logic [7:0]  VEC_EXT_BASE  = 8'h0c;
   localparam int unsigned VEC_ADDR_SHIFT = 2;

   // memory access profile codes
   localparam logic [1:0]  MEM_ONCHIP_W16_2 = 2'h0;
   localparam logic [1:0]  MEM_W8_2      = 2'h1;
   localparam logic [1:0]  MEM_W8_3      = 2'h2;
   localparam logic [1:0]  MEM_W16_3     = 2'h3;

   // state counts per step
   localparam logic [4:0]  ST_ACC_FAST   = 5'h04;
   localparam logic [4:0]  ST_ACC_W8_2   = 5'h08;
   localparam logic [4:0]  ST_ACC_W8_3   = 5'h0c;
   localparam logic [4:0]  ST_ACC_W16_3  = 5'h06;
   localparam logic [4:0]  ST_INTERNAL   = 5'h04;
   localparam logic [4:0]  ST_DECIDE_EXT = 5'h02;
   localparam logic [4:0]  ST_DECIDE_INT = 5'h01;

   // reset values of the mask flags and control bits
   localparam logic        RST_PRIMARY   = 1'b1;
   localparam logic        RST_SECONDARY = 1'b0;
   localparam logic        RST_MODE      = 1'b1;
   localparam logic [7:0]  RST_PRIO      = 8'h00;

   // exception entry sequencer states
   typedef enum logic [2:0] {
      IAM_IDLE     = 3'b000,
      IAM_DECIDE   = 3'b001,
      IAM_WAIT_END = 3'b010,
      IAM_SAVE     = 3'b011,
      IAM_VECTOR   = 3'b100,
      IAM_PREFETCH = 3'b101,
      IAM_INTERNAL = 3'b110
   } iam_state_t;

   // current mask setting seen by arbitration
   typedef struct packed {
      logic mask_mode_select;
      logic primary_mask_flag;
      logic secondary_mask_flag;
   } iam_mask_t;

   // acceptance result handed to the cpu
   typedef struct packed {
      logic       valid;
      logic [7:0] vector_num;
      logic [9:0] vector_addr;
   } iam_accept_t;

endpackage

// ===== logic/iam_ctrl.sv
`timescale 1ns/10ps
module iam_ctrl
   import iam_pkg::*;
#(
   parameter int unsigned NSRC = NUM_SRC
) (
   // clock and reset
   input  wire logic              mclk_in,
   input  wire logic              rst_b_in,
   input  wire logic              hw_standby_in,
   // request sources, index 0 = smallest vector number
   input  wire logic [NSRC-1:0]   src_cond_in,
   input  wire logic [NSRC-1:0]   src_enable_in,
   input  wire logic [NSRC-1:0]   src_is_ext_in,
   input  wire logic [NSRC-1:0]   src_group_in_a,
   input  wire logic [7:0]        src_vec_base_in,
   input  wire logic [NSRC*4-1:0] src_grp_sel_in,
   input  wire logic              nonmask_req_in,
   // control register images from the cpu side
   input  wire logic              mask_mode_select_in,
   input  wire logic [7:0]        priority_reg_a_in,
   input  wire logic [7:0]        priority_reg_b_in,
   input  wire logic              ccr_write_in,
   input  wire logic              ccr_primary_in,
   input  wire logic              ccr_secondary_in,
   // cpu handshake and memory timing
   input  wire logic              insn_boundary_in,
   input  wire logic [23:0]       next_pc_in,
   input  wire logic [1:0]        mem_profile_in,
   input  wire logic              mem_wait_in,
   // outputs toward the cpu
   output logic                   entry_busy_out,
   output logic                   stack_push_out,
   output logic [23:0]            saved_pc_out,
   output logic [7:0]             saved_ccr_out,
   output logic                   vector_fetch_out,
   output logic [9:0]             vector_addr_out,
   output logic                   prefetch_out,
   output logic                   handler_start_out,
   output logic [7:0]             accepted_vec_out,
   output logic                   primary_mask_flag_out,
   output logic                   secondary_mask_flag_out,
   output logic [NSRC-1:0]        pending_out
);

   //--------------------------------------------------------------
   // request gathering and masking
   //--------------------------------------------------------------
   iam_state_t        state_r;
   logic [4:0]        cnt_r;
   logic              primary_r;
   logic              secondary_r;
   logic [NSRC-1:0]   req;
   logic [NSRC-1:0]   lvl;
   logic [NSRC-1:0]   allow;
   logic [15:0]       grp_lvl;
   iam_mask_t         msk;
   iam_accept_t       acc_r;
   logic              sel_valid;
   logic [7:0]        sel_vec;
   logic              sel_ext;
   logic              sel_ext_r;
   logic [4:0]        acc_len;
   logic              nm_ok;
   logic              tick;

   // group levels from the two priority registers
   assign grp_lvl = {priority_reg_a_in, priority_reg_b_in};
   // mode and mask flags used in the very cycle of arbitration
   assign msk = '{mask_mode_select_in, primary_r, secondary_r};

   // per-source request, level and mask decision
   genvar g;
   generate
      for (g = 0; g < NSRC; g++) begin : g_src
         // condition forwarded only when enabled
         assign req[g] = src_cond_in[g] & src_enable_in[g];
         assign lvl[g] = grp_lvl[15 - src_grp_sel_in[g*4 +: 4]];
         // mode 1: primary flag alone
         // mode 0: level 0 by primary
         // level 1 only when both set
         assign allow[g] = msk.mask_mode_select ? ~msk.primary_mask_flag
                         : (~msk.primary_mask_flag
                            | (lvl[g] & ~msk.secondary_mask_flag));
      end
   endgenerate

   //--------------------------------------------------------------
   // arbitration
   //--------------------------------------------------------------
   // level 1 pass first, then level 0; lowest index wins within a pass
   always_comb begin
      sel_valid = 1'b0;
      sel_vec   = 8'h00;
      sel_ext   = 1'b0;
      // level 1 beats level 0
      for (int p = 1; p >= 0; p--) begin
         if (!sel_valid) begin
            // descending scan, so the lowest index is written last;
            // smaller vector wins a tie
            for (int i = NSRC - 1; i >= 0; i--) begin
               if (req[i] && allow[i] && (lvl[i] == p[0])) begin
                  sel_valid = 1'b1;
                  sel_vec   = src_vec_base_in + 8'(i);
                  sel_ext   = src_is_ext_in[i];
               end
            end
         end
      end
   end
   assign nm_ok = nonmask_req_in & ~hw_standby_in;

   //--------------------------------------------------------------
   // exception entry sequencer
   //--------------------------------------------------------------
   // access length per step, by memory profile
   always_comb begin
      case (mem_profile_in)
         MEM_ONCHIP_W16_2: acc_len = ST_ACC_FAST;
         MEM_W8_2:         acc_len = ST_ACC_W8_2;
         MEM_W8_3:         acc_len = ST_ACC_W8_3;
         MEM_W16_3:        acc_len = ST_ACC_W16_3;
         default:          acc_len = ST_ACC_FAST;
      endcase
   end

   // counter advances unless a bus wait state is inserted
   assign tick = ~mem_wait_in;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r   <= IAM_IDLE;
         cnt_r     <= 5'h00;
         acc_r     <= '0;
         sel_ext_r <= 1'b0;
      end else begin
         case (state_r)
            IAM_IDLE: begin
               // fresh evaluation while idle, pending kept by source
               if (nm_ok) begin
                  acc_r     <= '{1'b1, VEC_NONMASK, 10'(VEC_NONMASK)
                                 << VEC_ADDR_SHIFT};
                  sel_ext_r <= 1'b1;
                  state_r   <= IAM_DECIDE;
                  cnt_r     <= 5'h00;
               end else if (sel_valid) begin
                  acc_r     <= '{1'b1, sel_vec, 10'(sel_vec)
                                 << VEC_ADDR_SHIFT};
                  sel_ext_r <= sel_ext;
                  state_r   <= IAM_DECIDE;
                  cnt_r     <= 5'h00;
               end
            end
            IAM_DECIDE: begin
               // 2 states external, 1 on-chip
               if (cnt_r + 5'h01 >= (sel_ext_r ? ST_DECIDE_EXT
                                               : ST_DECIDE_INT)) begin
                  state_r <= IAM_WAIT_END;
                  cnt_r   <= 5'h00;
               end else begin
                  cnt_r <= cnt_r + 5'h01;
               end
            end
            IAM_WAIT_END: begin
               // current instruction completes first
               if (insn_boundary_in) begin
                  state_r <= IAM_SAVE;
                  cnt_r   <= 5'h00;
               end
            end
            IAM_SAVE, IAM_VECTOR, IAM_PREFETCH, IAM_INTERNAL: begin
               if (tick || state_r == IAM_INTERNAL) begin
                  if (cnt_r + 5'h01 >= ((state_r == IAM_INTERNAL)
                                        ? ST_INTERNAL : acc_len)) begin
                     cnt_r <= 5'h00;
                     case (state_r)
                        IAM_SAVE:     state_r <= IAM_VECTOR;
                        IAM_VECTOR:   state_r <= IAM_PREFETCH;
                        IAM_PREFETCH: state_r <= IAM_INTERNAL;
                        default: begin
                           state_r     <= IAM_IDLE;
                           acc_r.valid <= 1'b0;
                        end
                     endcase
                  end else begin
                     cnt_r <= cnt_r + 5'h01;
                  end
               end
            end
            default: state_r <= IAM_IDLE;
         endcase
      end
   end

   //--------------------------------------------------------------
   // mask flags
   //--------------------------------------------------------------
   // entry sets flags after the stack save; software writes otherwise
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         primary_r   <= RST_PRIMARY;
         secondary_r <= RST_SECONDARY;
      end else if (state_r == IAM_SAVE && tick
                   && cnt_r + 5'h01 >= acc_len) begin
         primary_r <= 1'b1;
         if (!mask_mode_select_in)
            secondary_r <= 1'b1;
      end else if (ccr_write_in) begin
         primary_r   <= ccr_primary_in;
         secondary_r <= ccr_secondary_in;
      end
   end

   //--------------------------------------------------------------
   // cpu facing outputs
   //--------------------------------------------------------------
   // saved image captured when the boundary is reached
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         saved_pc_out  <= 24'h000000;
         saved_ccr_out <= 8'h00;
      end else if (state_r == IAM_WAIT_END && insn_boundary_in) begin
         saved_pc_out  <= next_pc_in;
         saved_ccr_out <= {primary_r, secondary_r, 6'h00};
      end
   end

   // vector address and handler start
   assign vector_addr_out   = acc_r.vector_addr;
   assign accepted_vec_out  = acc_r.vector_num;
   assign vector_fetch_out  = (state_r == IAM_VECTOR);
   assign handler_start_out = (state_r == IAM_INTERNAL) && (cnt_r + 5'h01
                              >= ST_INTERNAL);
   assign stack_push_out    = (state_r == IAM_SAVE);
   assign prefetch_out      = (state_r == IAM_PREFETCH);
   assign entry_busy_out    = (state_r != IAM_IDLE);
   assign primary_mask_flag_out   = primary_r;
   assign secondary_mask_flag_out = secondary_r;
   assign pending_out       = req;    // unselected requests stay

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   sequence s_save_done;
      state_r == IAM_SAVE ##1 state_r == IAM_VECTOR;
   endsequence

   property p_mode1_mask;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (mask_mode_select_in && primary_r) |-> allow == '0;
   endproperty
   a_mode1_mask: assert property (p_mode1_mask)
      else $error("mode 1 masked source allowed");

   property p_nm_take;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (state_r == IAM_IDLE && nm_ok) |=>
         (state_r == IAM_DECIDE && acc_r.vector_num == VEC_NONMASK);
   endproperty
   a_nm_take: assert property (p_nm_take)
      else $error("nonmaskable request not taken");

   property p_mode0_lvl1;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (!mask_mode_select_in && primary_r && !secondary_r)
         |-> allow == lvl;
   endproperty
   a_mode0_lvl1: assert property (p_mode0_lvl1)
      else $error("mode 0 level 1 masking wrong");

   property p_flags_set;
      @(posedge mclk_in) disable iff (!rst_b_in)
      s_save_done |-> primary_r &&
         (mask_mode_select_in || secondary_r);
   endproperty
   a_flags_set: assert property (p_flags_set)
      else $error("mask flags not set on entry");

   property p_wait_end;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (state_r == IAM_WAIT_END && !insn_boundary_in)
         |=> state_r == IAM_WAIT_END;
   endproperty
   a_wait_end: assert property (p_wait_end)
      else $error("entry before instruction end");

   property p_internal_len;
      @(posedge mclk_in) disable iff (!rst_b_in)
      $rose(state_r == IAM_INTERNAL) |->
         (state_r == IAM_INTERNAL) [*4] ##1 state_r == IAM_IDLE;
   endproperty
   a_internal_len: assert property (p_internal_len)
      else $error("internal processing not 4 states");

   property p_decide_int;
      @(posedge mclk_in) disable iff (!rst_b_in)
      ($rose(state_r == IAM_DECIDE) && !sel_ext_r)
         |=> state_r == IAM_WAIT_END;
   endproperty
   a_decide_int: assert property (p_decide_int)
      else $error("on-chip decision not 1 state");

   property p_vec_addr;
      @(posedge mclk_in) disable iff (!rst_b_in)
      vector_fetch_out |->
         vector_addr_out == (10'(accepted_vec_out) << VEC_ADDR_SHIFT);
   endproperty
   a_vec_addr: assert property (p_vec_addr)
      else $error("vector address wrong");

   // external or nonmaskable: two decision states, then the wait
   sequence s_ext_decide;
      state_r == IAM_DECIDE ##1 state_r == IAM_WAIT_END;
   endsequence

   property p_decide_ext;
      @(posedge mclk_in) disable iff (!rst_b_in)
      ($rose(state_r == IAM_DECIDE) && sel_ext_r) |=> s_ext_decide;
   endproperty
   a_decide_ext: assert property (p_decide_ext)
      else $error("external decision not 2 states");

   // mode 1 ignores the secondary flag entirely
   property p_mode1_open;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (mask_mode_select_in && !primary_r) |-> allow == '1;
   endproperty
   a_mode1_open: assert property (p_mode1_open)
      else $error("mode 1 open source blocked");

   property p_mode0_open;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (!mask_mode_select_in && !primary_r) |-> allow == '1;
   endproperty
   a_mode0_open: assert property (p_mode0_open)
      else $error("mode 0 open source blocked");

   property p_mode0_lvl0;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (!mask_mode_select_in && primary_r) |-> (allow & ~lvl) == '0;
   endproperty
   a_mode0_lvl0: assert property (p_mode0_lvl0)
      else $error("mode 0 level 0 source not masked");

   // a disabled condition alone must never start an entry
   property p_idle_hold;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (state_r == IAM_IDLE && !nm_ok
       && !(|(src_cond_in & src_enable_in))) |=> state_r == IAM_IDLE;
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("entry without enabled request");

   property p_pc_saved;
      @(posedge mclk_in) disable iff (!rst_b_in)
      (state_r == IAM_WAIT_END && insn_boundary_in)
         |=> saved_pc_out == $past(next_pc_in);
   endproperty
   a_pc_saved: assert property (p_pc_saved)
      else $error("resume address not saved");

endmodule

// ===== tb/iam_cpu_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// cpu core stand-in: instruction ends, memory waits
// ----------------------------------------
module iam_cpu_model (
   // clock and reset
   input  wire logic       mclk_in,
   input  wire logic       rst_b_in,
   // pacing set by the bench
   input  wire logic [3:0] gap_in,
   input  wire logic [3:0] wait_len_in,
   // design side
   input  wire logic       stack_push_in,
   output logic            insn_boundary_out,
   output logic            mem_wait_out
);
   logic [3:0] gcnt_r;
   logic [3:0] wcnt_r;
   logic       push_d_r;

   // instruction end every cycle at gap 0, else one per gap+1 cycles
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         gcnt_r <= 4'h0;
         insn_boundary_out <= 1'b0;
      end else if (gcnt_r >= gap_in) begin
         gcnt_r <= 4'h0;
         insn_boundary_out <= 1'b1;
      end else begin
         gcnt_r <= gcnt_r + 4'h1;
         insn_boundary_out <= 1'b0;
      end
   end

   // slow external memory: stall the stack save for wait_len cycles
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wcnt_r <= 4'h0;
         push_d_r <= 1'b0;
      end else begin
         push_d_r <= stack_push_in;
         if (stack_push_in && !push_d_r)
            wcnt_r <= wait_len_in;
         else if (wcnt_r != 4'h0)
            wcnt_r <= wcnt_r - 4'h1;
      end
   end
   assign mem_wait_out = (wcnt_r != 4'h0);
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
// ----------------------------------------
// bench: driver notes expected entries, monitor checks them
// ----------------------------------------
module tb;
   import iam_pkg::*;
   localparam int NS = 42;
   typedef struct {
      int          vec;
      logic [23:0] pc;
      logic [1:0]  condition_code_reg;
      logic [1:0]  flg;
      int          lat;
      int          acc;
      realtime     t0;
   } iam_note_t;
   logic          mclk_in = 1'b0;
   logic          rst_b_in = 1'b0;
   logic          standby = 1'b0, nm = 1'b0, mode = 1'b1, cw = 1'b0;
   logic          ci = 1'b0, cu = 1'b0, fi = 1'b1, fu = 1'b0;
   logic          bnd, mwait, push_d = 1'b0, bnd_d = 1'b0;
   logic [NS-1:0] cond = '0, en = '0;
   logic [NS*4-1:0] grp;
   logic [7:0]    pa = 8'h00, pb = 8'h00;
   logic [23:0]   pc = 24'h000000;
   logic [1:0]    prof = 2'h0;
   logic [3:0]    gap = 4'h0, wl = 4'h0;
   logic          busy, push, vfet, pref, hstart, pri, sec;
   logic [23:0]   spc;
   logic [7:0]    sccr, avec;
   logic [9:0]    vaddr;
   logic [NS-1:0] pend;
   int            error_cnt = 0, check_count = 0, done = 0;
   int            vf_n = 0, pf_n = 0;
   iam_note_t     q[$];
   iam_note_t     nm_m;

   always #2.5 mclk_in = ~mclk_in;
   initial for (int i = 0; i < NS; i++) grp[i*4 +: 4] = 4'(i / 3);

   iam_ctrl #(.NSRC(NS)) u_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
      .hw_standby_in(standby), .src_cond_in(cond), .src_enable_in(en),
      .src_is_ext_in(NS'(8'hff)), .src_group_in_a('0),
      .src_vec_base_in(VEC_EXT_BASE), .src_grp_sel_in(grp),
      .nonmask_req_in(nm), .mask_mode_select_in(mode),
      .priority_reg_a_in(pa), .priority_reg_b_in(pb), .ccr_write_in(cw),
      .ccr_primary_in(ci), .ccr_secondary_in(cu), .insn_boundary_in(bnd),
      .next_pc_in(pc), .mem_profile_in(prof), .mem_wait_in(mwait),
      .entry_busy_out(busy), .stack_push_out(push), .saved_pc_out(spc),
      .saved_ccr_out(sccr), .vector_fetch_out(vfet),
      .vector_addr_out(vaddr), .prefetch_out(pref),
      .handler_start_out(hstart), .accepted_vec_out(avec),
      .primary_mask_flag_out(pri), .secondary_mask_flag_out(sec),
      .pending_out(pend));
   iam_cpu_model u_cpu (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
      .gap_in(gap), .wait_len_in(wl), .stack_push_in(push),
      .insn_boundary_out(bnd), .mem_wait_out(mwait));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                      input string msg);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // reference arbitration: highest level first, then lowest index
   function automatic int pick(input logic [NS-1:0] c, input logic n);
      logic [15:0]   lv;
      logic [NS-1:0] p;
      int            b;
      lv = {pa, pb};
      p = c & en;
      b = -1;
      if (n && !standby)
         return int'(VEC_NONMASK);
      for (int i = NS - 1; i >= 0; i--)
         if (p[i] && (!fi || (lv[15 - i / 3] && !mode && !fu)) &&
             (b < 0 || lv[15 - i / 3] >= lv[15 - b / 3]))
            b = i;
      return (b < 0) ? -1 : b + 12;
   endfunction

   // one request set; a ccr write in the same cycle voids the latency
   task automatic step(input logic [NS-1:0] c, input logic n,
                       input logic w, input logic wi, input logic wu);
      iam_note_t nt;
      int        k;
      @(posedge mclk_in);
      cond <= c;
      nm <= n;
      cw <= w;
      ci <= wi;
      cu <= wu;
      if (w) begin
         fi = wi;
         fu = wu;
      end
      nt.vec = pick(c, n);
      nt.t0 = $realtime;
      nt.pc = 24'($urandom);
      pc <= nt.pc;
      @(posedge mclk_in);
      cw <= 1'b0;
      if (nt.vec < 0) begin
         repeat (40) @(posedge mclk_in);
         chk(64'(busy), 64'h0, "masked request entered");
         chk(64'(pend), 64'(c & en), "pending set");
      end else begin
         nt.condition_code_reg = {fi, fu};
         nt.flg = {1'b1, mode ? fu : 1'b1};
         nt.acc = (prof == 2'h0) ? 4 : (prof == 2'h1) ? 8 :
            (prof == 2'h2) ? 12 : 6;
         nt.lat = (w || gap != 4'h0) ? -1 : ((nt.vec < 20) ? 2 : 1) + 6 +
            3 * nt.acc + int'(wl);
         q.push_back(nt);
         fi = 1'b1;
         fu = nt.flg[0];
         for (k = 0; k < 300 && push !== 1'b1; k++) @(posedge mclk_in);
         if (nt.vec == 7)
            nm <= 1'b0;
         else
            cond <= c & ~(NS'(1) << (nt.vec - 12));
         k = done;
         for (int j = 0; j < 300 && done == k; j++) @(posedge mclk_in);
         chk(64'(done - k), 64'h1, "entry not completed");
      end
   endtask

   // monitor: each handler start consumes the oldest note
   always @(posedge mclk_in) begin
      if (rst_b_in && push === 1'b1 && !push_d)
         chk(64'(bnd_d), 64'h1, "save before instruction end");
      push_d <= push;
      bnd_d <= bnd;
      // step lengths of vector fetch and prefetch, per entry
      if (vfet === 1'b1)
         vf_n++;
      if (pref === 1'b1)
         pf_n++;
      if (rst_b_in && hstart === 1'b1) begin
         if (q.size() == 0) begin
            chk(64'h0, 64'h1, "unexpected entry");
         end else begin
            nm_m = q.pop_front();
            chk(64'(avec), 64'(nm_m.vec), "vector");
            chk(64'(vaddr), 64'(nm_m.vec * 4), "vector address");
            chk(64'(spc), 64'(nm_m.pc), "saved pc");
            chk(64'(sccr[7:6]), 64'(nm_m.condition_code_reg), "saved ccr");
            chk(64'({pri, sec}), 64'(nm_m.flg), "flags");
            chk(64'(vf_n), 64'(nm_m.acc), "fetch length");
            chk(64'(pf_n), 64'(nm_m.acc), "prefetch length");
            if (nm_m.lat >= 0)
               chk(64'(int'(($realtime - nm_m.t0) / 5.0)), 64'(nm_m.lat),
                   "response time");
         end
         vf_n = 0;
         pf_n = 0;
         done <= done + 1;
      end
   end

   // tests need about 3000 cycles; wide margin, still a bounded run
   initial begin
      #(40000 * 5);
      error_cnt++;
      finish_test();
   end

   initial begin
      void'($urandom(32'hec445e0f));
      repeat (20) @(posedge mclk_in);
      rst_b_in <= 1'b1;
      en <= NS'({$urandom, $urandom});
      @(posedge mclk_in);
      chk(64'({pri, sec}), 64'h2, "reset flags");
      // one-level mode with primary flag set: all maskables held
      step(NS'({$urandom, $urandom}), 1'b0, 1'b0, 1'b0,
           1'b0);
      $display("test masked done");
      // nonmaskable blocked in standby, then taken despite the mask
      standby <= 1'b1;
      step('0, 1'b1, 1'b0, 1'b0, 1'b0);
      nm <= 1'b0;
      standby <= 1'b0;
      en <= '1;
      step('0, 1'b1, 1'b0, 1'b0, 1'b0);
      $display("test nonmaskable done");
      // every memory profile, external and on-chip decision
      for (int p = 0; p < 5; p++) begin
         prof <= 2'(p);
         wl <= (p == 4) ? 4'h3 : 4'h0;
         for (int e = 0; e < 2; e++) begin
            step('0, 1'b0, 1'b1, 1'b0, 1'b0);
            step(NS'(1) << (e ? 2 : 20), 1'b0, 1'b0, 1'b0, 1'b0);
         end
      end
      wl <= 4'h0;
      gap <= 4'h7;
      step('0, 1'b1, 1'b0, 1'b0, 1'b0);
      gap <= 4'h0;
      $display("test timing done");
      // random levels, modes and masks; drain pending in order
      for (int r = 0; r < 8; r++) begin
         step('0, 1'b0, 1'b1, 1'b1, 1'b1);
         mode <= 1'($urandom);
         pa <= 8'($urandom);
         pb <= 8'($urandom);
         en <= NS'({$urandom, $urandom} | {$urandom, $urandom});
         @(posedge mclk_in);
         step(NS'({$urandom, $urandom}), 1'b0, 1'b1, 1'($urandom),
              1'($urandom));
         repeat (4)
            step(cond, 1'b0, 1'b1, 1'($urandom),
                 1'($urandom));
      end
      $display("test arbitration done");
      finish_test();
   end
endmodule
